// [testbench/link_receiver_model.sv]
`include "serial_framer_consts.svh"
`default_nettype none

module link_receiver_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Serial link
    input  wire logic       serial_out_pos,
    input  wire logic       serial_out_neg,
    // Decoded stream
    output logic            char_valid,
    output logic [9:0]      char_data,
    output logic            frame_start,
    output logic            link_fault
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] bit_cnt;
    logic [9:0] shreg;
    logic [1:0] sof_step;
    int         idle_run;

    // ====================================================================
    // Deserializer and frame lock
    always_ff @(posedge core_clk) begin
        char_valid <= 1'b0;
        frame_start <= 1'b0;
        link_fault <= !sys_rst && (serial_out_neg === serial_out_pos);
        if (sys_rst) begin
            bit_cnt <= 4'h0;
            idle_run <= 0;
            sof_step <= 2'h0;
        end else if (bit_cnt == 4'h0) begin
            if (serial_out_pos == `START_LEVEL) begin
                bit_cnt <= 4'h1;
            end
        end else if (bit_cnt <= 4'hA) begin
            shreg <= {shreg[8:0], serial_out_pos};
            bit_cnt <= bit_cnt + 4'h1;
        end else begin
            bit_cnt <= 4'h0;
            if (serial_out_pos != `STOP_LEVEL) begin
                // Lost alignment: demand a fresh idle run before locking again
                link_fault <= 1'b1;
                idle_run <= 0;
                sof_step <= 2'h0;
            end else begin
                char_valid <= 1'b1;
                char_data <= shreg;
                idle_run <= (shreg == `IDLE_CHAR) ? idle_run + 1 : 0;
                case (sof_step)
                    2'h0: sof_step <= (shreg == `SOF_MARK_CHAR && idle_run >= 2) ? 2'h1 : 2'h0;
                    2'h1: sof_step <= (shreg == `SOF_GAP_CHAR) ? 2'h2 : 2'h0;
                    default: begin
                        frame_start <= (shreg == `SOF_MARK_CHAR);
                        sof_step <= 2'h0;
                    end
                endcase
            end
        end
    end
endmodule // link_receiver_model

`default_nettype wire

// [testbench/serial_pixel_stream_framer_bench.sv]
`include "serial_framer_consts.svh"
`default_nettype none

module serial_pixel_stream_framer_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // Short frame keeps the run small
    localparam int AC     = 8;
    localparam int HB     = 8;
    localparam int AR     = 4;
    localparam int VB     = 2;
    localparam int EB     = 6;
    localparam int ROW    = AC + HB;
    localparam int ROWS   = AR + VB;
    localparam int NCHARS = ROW * ROWS * 2 + ROW;

    logic       core_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [9:0] pixel_in = 10'h000;
    logic       pixel_req;
    logic       serial_out_pos;
    logic       serial_out_neg;
    logic       pixel_clock_out;
    logic       char_valid;
    logic [9:0] char_data;
    logic       frame_start;
    logic       link_fault;

    int         err_count = 0;
    int         samples_checked = 0;
    int         char_count = 0;
    int         fs_count = 0;
    int         row = ROWS - 1;
    int         col = 0;
    int         cyc = 0;
    int         last_tog = -1;
    int         last_req = -1;
    int         req_n = 0;
    logic       last_pclk = 1'b0;
    logic [9:0] pix_q[$];
    logic [9:0] exp_c;

    serial_pixel_stream_framer #(
        .ACTIVE_COLS(AC),
        .HBLANK_COLS(HB),
        .ACTIVE_ROWS(AR),
        .VBLANK_ROWS(VB),
        .EDGE_BLANK (EB)
    ) dut (
        .core_clk       (core_clk),
        .sys_rst        (sys_rst),
        .pixel_in       (pixel_in),
        .pixel_req      (pixel_req),
        .serial_out_pos (serial_out_pos),
        .serial_out_neg (serial_out_neg),
        .pixel_clock_out(pixel_clock_out)
    );

    link_receiver_model partner (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .serial_out_pos(serial_out_pos),
        .serial_out_neg(serial_out_neg),
        .char_valid    (char_valid),
        .char_data     (char_data),
        .frame_start   (frame_start),
        .link_fault    (link_fault)
    );

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ====================================================================
    // Reference model of the character stream
    always @(negedge core_clk) begin
        if (!sys_rst) begin
            cyc++;
            if (pixel_clock_out !== last_pclk) begin
                if (last_tog >= 0) check(12'(cyc - last_tog), 12'h006);
                last_tog = cyc;
                last_pclk = pixel_clock_out;
            end
            if (pixel_req === 1'b1) begin
                pix_q.push_back(pixel_in == 10'h3FF ? 10'h3FE : pixel_in);
                if (req_n % AC != 0) check(12'(cyc - last_req), 12'h00C);
                last_req = cyc;
                req_n++;
            end
            if (link_fault === 1'b1) check(12'h001, 12'h000);
            if (char_valid === 1'b1) begin
                if (row < AR && col < AC) begin
                    exp_c = (pix_q.size() > 0) ? pix_q.pop_front() : 10'h3FF;
                    check({2'h0, char_data}, {2'h0, exp_c});
                end else if (row == ROWS - 1 && col >= ROW - EB && col < ROW - EB + 3) begin
                    exp_c = (col == ROW - EB + 1) ? `SOF_GAP_CHAR : `SOF_MARK_CHAR;
                    check({2'h0, char_data}, {2'h0, exp_c});
                end else begin
                    check({2'h0, char_data}, {2'h0, `IDLE_CHAR});
                end
                check({11'h000, frame_start}, {11'h000, row == ROWS - 1 && col == ROW - EB + 2});
                if (frame_start === 1'b1) fs_count++;
                char_count++;
                col++;
                if (col == ROW) begin
                    col = 0;
                    row = (row + 1) % ROWS;
                end
            end
        end
    end

    // ====================================================================
    // Main sequence
    initial begin
        int i;
        void'($urandom(32'h47988801));
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 20000 && char_count < NCHARS; i++) begin
            @(posedge core_clk);
            // Full-scale code is frequent on purpose, to exercise the clamp
            pixel_in <= ($urandom % 4 == 0) ? 10'h3FF : 10'($urandom);
        end
        check(12'(char_count), 12'(NCHARS));
        check(12'(fs_count), 12'h003);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check({8'h00, serial_out_pos, serial_out_neg, pixel_clock_out, pixel_req}, 12'h008);
        give_verdict();
    end
endmodule // serial_pixel_stream_framer_bench

`default_nettype wire

// [verilog/char_buffer.sv]
`include "serial_framer_consts.svh"
`default_nettype none

module char_buffer #(
    parameter int WIDTH = `PAYLOAD_BITS,
    parameter int DEPTH = `BUF_DEPTH
) (
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  sys_rst,
    // Streams
    char_stream_if.snk in_s,
    char_stream_if.src out_s
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH != 2 || WIDTH < 1) begin : g_bad
            $error("char_buffer: DEPTH must be 2 and WIDTH positive");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;

    // ====================================================================
    // Handshake
    assign in_s.ready  = (count != (PW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data  = store[rd_ptr];
    assign push        = in_s.valid && in_s.ready;
    assign pop         = out_s.valid && out_s.ready;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // ====================================================================
    // Storage and pointers
    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

endmodule // char_buffer

`default_nettype wire

// [verilog/char_stream_if.sv]
`default_nettype none

interface char_stream_if #(
    parameter int WIDTH = 10
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// [verilog/serial_framer_consts.svh]
`ifndef SERIAL_FRAMER_CONSTS_SVH
`define SERIAL_FRAMER_CONSTS_SVH

// ====================================================================
// Character format
`define CHAR_BITS          12
`define PAYLOAD_BITS       10
`define START_LEVEL        1'b0
`define STOP_LEVEL         1'b1
`define SOF_MARK_CHAR      10'h3FF
`define SOF_GAP_CHAR       10'h000
`define IDLE_CHAR          10'h000
`define PIXEL_CLAMP_CHAR   10'h3FE

// ====================================================================
// Clock division: bit clock / 6 = master rate, master / 2 = pixel rate
`define MASTER_DIV         6
`define BIT_CLOCK_MHZ      162
`define MASTER_CLOCK_MHZ   27
`define MASTER_TICKS       (`BIT_CLOCK_MHZ / `MASTER_CLOCK_MHZ)

// ====================================================================
// Default frame timing, in pixel clocks and rows
`define ACTIVE_COLS        640
`define HBLANK_COLS        244
`define ACTIVE_ROWS        480
`define VBLANK_ROWS        29
`define FRAME_EDGE_BLANK   6
`define SOF_CHARS          3

// ====================================================================
// Buffer
`define BUF_DEPTH          2

`endif

// [verilog/serial_framer_pkg.sv]
`default_nettype none

package serial_framer_pkg;

    typedef enum logic [1:0] {
        K_IDLE,
        K_PIXEL,
        K_SOF_MARK,
        K_SOF_GAP
    } char_kind_e;

    typedef enum logic {
        SER_IDLE,
        SER_SHIFT
    } ser_state_e;

endpackage

`default_nettype wire

// [verilog/serial_pixel_stream_framer.sv]
// Overview of operation
// RULE_01 - Each pixel leaves as 12 bits: start bit, 10-bit payload, stop bit.
// RULE_02 - Serializer runs on the bit clock; a divider sets the slower rates.
// RULE_03 - Pixel rate is a fixed ratio of the input clock, 162 MHz nominal.
// RULE_04 - One stream carries data and timing, driven on a differential pair.
// RULE_05 - Frame start sends characters 0x3FF, 0x0, 0x3FF.
// RULE_06 - The start-of-frame triple never appears inside pixel data.
// RULE_07 - No separate row or frame strobe outputs exist.
// RULE_08 - Receiver finds the triple and rebuilds strobes with counters.
// RULE_09 - Receiver first locks on a run of idle characters, then seeks the triple.
// RULE_10 - Frame timing and blanking match the default parallel timing.
// RULE_11 - Progressive scan with horizontal and vertical blanking around pixels.
// RULE_12 - Controller leaves pixel clock control and read mode bits 15:14 default.
// RULE_13 - One 10-bit pixel per pixel clock during valid rows.
// RULE_14 - Receiver checks start and stop bits and realigns on idle.
// RULE_15 - Fixed bit order, fixed start and stop polarity, constant latency.
`include "serial_framer_consts.svh"
`default_nettype none

module serial_pixel_stream_framer #(
    parameter int ACTIVE_COLS = `ACTIVE_COLS,
    parameter int HBLANK_COLS = `HBLANK_COLS,
    parameter int ACTIVE_ROWS = `ACTIVE_ROWS,
    parameter int VBLANK_ROWS = `VBLANK_ROWS,
    parameter int EDGE_BLANK  = `FRAME_EDGE_BLANK
) (
    // Clock (serial bit clock) and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Pixel readout
    input  wire logic [9:0] pixel_in,
    output logic            pixel_req,
    // Serial link
    output logic            serial_out_pos,
    output logic            serial_out_neg,
    output logic            pixel_clock_out
);
    localparam int H_TOTAL = ACTIVE_COLS + HBLANK_COLS;
    localparam int V_TOTAL = ACTIVE_ROWS + VBLANK_ROWS;
    localparam logic [9:0] H_LAST  = 10'(H_TOTAL - 1);
    localparam logic [8:0] V_LAST  = 9'(V_TOTAL - 1);
    localparam logic [9:0] H_ACT   = 10'(ACTIVE_COLS);
    localparam logic [8:0] V_ACT   = 9'(ACTIVE_ROWS);
    localparam logic [9:0] SOF_COL = 10'(H_TOTAL - EDGE_BLANK);
    localparam logic [2:0] DIV_LAST = 3'(`MASTER_DIV - 1);
    localparam logic [3:0] BIT_LAST = 4'(`CHAR_BITS - 1);

    generate
        if (H_TOTAL > 1024 || V_TOTAL > 512 || EDGE_BLANK < `SOF_CHARS || HBLANK_COLS < EDGE_BLANK
            || `MASTER_TICKS != `MASTER_DIV) begin : g_bad
            $error("serial_pixel_stream_framer: timing parameters out of range");
        end
    endgenerate

    char_stream_if #(.WIDTH(`PAYLOAD_BITS)) fill_s ();
    char_stream_if #(.WIDTH(`PAYLOAD_BITS)) drain_s ();

    logic [2:0]                      div_cnt;
    logic                            master_tick;
    logic                            pend;
    logic                            push;
    logic [9:0]                      hcount;
    logic [8:0]                      vcount;
    logic                            line_active;
    serial_framer_pkg::char_kind_e   kind;
    logic [9:0]                      next_char;
    serial_framer_pkg::ser_state_e   ser_state;
    logic [3:0]                      bit_cnt;
    logic [`CHAR_BITS-1:0]           shreg;
    logic                            ld;

    // ====================================================================
    // Clock division
    // Master tick every 6 bit clocks; pixel clock toggles on it, so one
    // pixel period equals exactly one 12-bit character time.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_cnt <= '0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0; // RULE_02
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    assign master_tick = (div_cnt == DIV_LAST);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pixel_clock_out <= 1'b0;
        end else if (master_tick) begin
            pixel_clock_out <= ~pixel_clock_out; // RULE_03
        end
    end

    // A character slot waits here until the buffer takes it; the counters
    // only advance on acceptance, so a stall delays rather than drops.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pend <= 1'b0;
        end else if (master_tick && pixel_clock_out) begin
            pend <= 1'b1; // RULE_13
        end else if (push) begin
            pend <= 1'b0;
        end
    end

    assign push = pend && fill_s.ready;

    // ====================================================================
    // Frame timing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hcount <= '0;
            vcount <= V_LAST;
        end else if (push) begin
            if (hcount == H_LAST) begin
                hcount <= '0; // RULE_10
                vcount <= (vcount == V_LAST) ? 9'h000 : vcount + 9'h001;
            end else begin
                hcount <= hcount + 10'h001;
            end
        end
    end

    assign line_active = (hcount < H_ACT) && (vcount < V_ACT); // RULE_11

    // ====================================================================
    // Character selection
    // Frame start marker sits EDGE_BLANK pixel clocks before the first row, where the
    // frame strobe would rise; strobes themselves are never output.
    always_comb begin
        kind = serial_framer_pkg::K_IDLE;
        if (line_active) begin
            kind = serial_framer_pkg::K_PIXEL;
        end else if (vcount == V_LAST && hcount == SOF_COL) begin
            kind = serial_framer_pkg::K_SOF_MARK; // RULE_05
        end else if (vcount == V_LAST && hcount == SOF_COL + 10'h001) begin
            kind = serial_framer_pkg::K_SOF_GAP;
        end else if (vcount == V_LAST && hcount == SOF_COL + 10'h002) begin
            kind = serial_framer_pkg::K_SOF_MARK;
        end
    end

    always_comb begin
        case (kind)
            serial_framer_pkg::K_PIXEL: begin
                // Full scale is pulled down one code so pixels can never
                // form the marker triple.
                next_char = (pixel_in == `SOF_MARK_CHAR) ? `PIXEL_CLAMP_CHAR : pixel_in; // RULE_06
            end
            serial_framer_pkg::K_SOF_MARK: begin
                next_char = `SOF_MARK_CHAR;
            end
            serial_framer_pkg::K_SOF_GAP: begin
                next_char = `SOF_GAP_CHAR;
            end
            default: begin
                next_char = `IDLE_CHAR; // RULE_07
            end
        endcase
    end

    assign fill_s.valid = pend;
    assign fill_s.data  = next_char;
    assign pixel_req    = push && line_active;

    char_buffer #(
        .WIDTH (`PAYLOAD_BITS),
        .DEPTH (`BUF_DEPTH)
    ) u_buffer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .in_s     (fill_s),
        .out_s    (drain_s)
    );

    // ====================================================================
    // Serializer, MSB of payload first
    assign drain_s.ready = (ser_state == serial_framer_pkg::SER_IDLE) || (bit_cnt == BIT_LAST);
    assign ld            = drain_s.valid && drain_s.ready;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ser_state <= serial_framer_pkg::SER_IDLE;
            bit_cnt   <= '0;
            shreg     <= {`CHAR_BITS{`STOP_LEVEL}};
        end else if (ld) begin
            ser_state <= serial_framer_pkg::SER_SHIFT;
            bit_cnt   <= '0;
            shreg     <= {`START_LEVEL, drain_s.data, `STOP_LEVEL}; // RULE_01
        end else begin
            case (ser_state)
                serial_framer_pkg::SER_SHIFT: begin
                    shreg <= {shreg[`CHAR_BITS-2:0], `STOP_LEVEL}; // RULE_15
                    if (bit_cnt == BIT_LAST) begin
                        ser_state <= serial_framer_pkg::SER_IDLE;
                    end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                default: begin
                    shreg <= {`CHAR_BITS{`STOP_LEVEL}};
                end
            endcase
        end
    end

    // Idle line rests at stop level; both legs come from one flop
    assign serial_out_pos = shreg[`CHAR_BITS-1]; // RULE_04
    assign serial_out_neg = ~shreg[`CHAR_BITS-1];

    // ====================================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_mark_push;
        push && next_char == `SOF_MARK_CHAR;
    endsequence

    sequence s_gap_push;
        push && next_char == `SOF_GAP_CHAR && kind == serial_framer_pkg::K_SOF_GAP;
    endsequence

    a_char_framing: assert property (ld |=> (serial_out_pos == `START_LEVEL) ##11 (serial_out_pos == `STOP_LEVEL)) // RULE_01
        else $error("character start or stop bit wrong");

    a_master_divide: assert property (master_tick |=> (!master_tick) [*5] ##1 master_tick) // RULE_02
        else $error("master tick not every six bit clocks");

    a_pixel_rate: assert property ($rose(pixel_clock_out) |=> (!$rose(pixel_clock_out)) [*8] // RULE_03
        ##1 (!$rose(pixel_clock_out)) [*3] ##1 $rose(pixel_clock_out))
        else $error("pixel clock period not twelve bit clocks");

    a_diff_pair: assert property (serial_out_pos != serial_out_neg) // RULE_04
        else $error("serial pair not complementary");

    a_sof_triple: assert property (push && kind == serial_framer_pkg::K_SOF_MARK && hcount == SOF_COL // RULE_05
        |-> ##[1:24] s_gap_push ##[1:24] s_mark_push)
        else $error("start of frame triple broken");

    a_pixel_no_mark: assert property (push && line_active |-> next_char != `SOF_MARK_CHAR) // RULE_06
        else $error("pixel carries marker value");

    a_blank_idle: assert property (push && kind == serial_framer_pkg::K_IDLE |-> next_char == `IDLE_CHAR && !line_active) // RULE_11
        else $error("blanking character not idle");

    a_row_wrap: assert property (push && hcount == H_LAST |=> hcount == 10'h000 && $changed(vcount)) // RULE_10
        else $error("row period wrong");

    a_pixel_request: assert property (pixel_req |-> line_active && kind == serial_framer_pkg::K_PIXEL) // RULE_13
        else $error("pixel taken outside active row");

    a_shift_length: assert property (ld |=> (ser_state == serial_framer_pkg::SER_SHIFT && bit_cnt == 4'h0) ##11 (bit_cnt == BIT_LAST)) // RULE_15
        else $error("serializer latency not constant");

endmodule // serial_pixel_stream_framer

`default_nettype wire
